// ### hdl/scd_card_if.sv
// top of the smart card interface control: sequencer, faults, interrupt, lines
// assumes all pins are synchronous to clk_sys; analog parts sit outside
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
module scd_card_if
   import scd_pkg::*;
#(
   parameter int DEBOUNCE_COUNT = DEBOUNCE_CYC
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic div_sel_a,
   input wire logic div_sel_b,
   input wire logic ext_clock_in,
   input wire logic card_supply_sel,
   input wire logic card_detect_in_n,
   input wire logic card_detect_in,
   input wire logic activate_cmd_n,
   input wire logic host_reset_in,
   input wire logic fault_overload,
   input wire logic fault_overheat,
   input wire logic card_supply_ok,
   input wire logic host_supply_ok,
   output logic card_supply_out,
   output logic card_supply_5v,
   output logic card_clock_out,
   output logic card_reset_out,
   input wire logic host_serial_in,
   output logic host_serial_out,
   output logic host_serial_oe_n,
   input wire logic host_aux_line_a_in,
   output logic host_aux_line_a_out,
   output logic host_aux_line_a_oe_n,
   input wire logic host_aux_line_b_in,
   output logic host_aux_line_b_out,
   output logic host_aux_line_b_oe_n,
   input wire logic card_serial_line_in,
   output logic card_serial_line_out,
   output logic card_serial_line_oe_n,
   input wire logic card_aux_line_a_in,
   output logic card_aux_line_a_out,
   output logic card_aux_line_a_oe_n,
   input wire logic card_aux_line_b_in,
   output logic card_aux_line_b_out,
   output logic card_aux_line_b_oe_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   output logic irq_n
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   scd_seq_t seq_r;
   scd_seq_t seq_nxt;
   logic [STEP_W-1:0] step_r;
   logic [STEP_W-1:0] step_nxt;
   logic cmd_prev_r;
   logic cmd_prev_nxt;
   logic sup_on_r;
   logic sup_on_nxt;
   logic sup_5v_r;
   logic sup_5v_nxt;
   logic rst_out_r;
   logic rst_out_nxt;
   logic clk_en;
   logic line_en;
   logic present;
   logic pres_prev_r;
   logic pres_prev_nxt;
   logic [NUM_EV-1:1] flt_now;
   logic [NUM_EV-1:1] flt_prev_r;
   logic [NUM_EV-1:1] flt_prev_nxt;
   logic [NUM_EV-1:0] ev;
   logic [NUM_EV-1:0] status_r;
   logic [NUM_EV-1:0] status_nxt;
   logic [NUM_EV-1:0] mask_r;
   logic [NUM_EV-1:0] mask_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic irq_n_r;
   logic irq_n_nxt;
   logic cmd_fall;
   logic deact;
   logic step_done;
   logic [NUM_LINES-1:0] host_in_v;
   logic [NUM_LINES-1:0] host_out_v;
   logic [NUM_LINES-1:0] host_oe_n_v;
   logic [NUM_LINES-1:0] card_in_v;
   logic [NUM_LINES-1:0] card_out_v;
   logic [NUM_LINES-1:0] card_oe_n_v;

   // ----------------------------------------------------------------
   // presence detection and debounce
   // ----------------------------------------------------------------
   scd_debounce #(
      .CNT_W(DEBOUNCE_W),
      .CNT_MAX(DEBOUNCE_COUNT)
   ) u_debounce (
      .clk_sys(clk_sys),
      .rst(rst),
      .raw_in(!card_detect_in_n || card_detect_in),
      .present(present)
   );

   // ----------------------------------------------------------------
   // card clock divider
   // ----------------------------------------------------------------
   scd_clk_div u_clk_div (
      .clk_sys(clk_sys),
      .rst(rst),
      .enable(clk_en),
      .ext_clock_in(ext_clock_in),
      .div_code({div_sel_b, div_sel_a}),
      .clk_out(card_clock_out)
   );

   // ----------------------------------------------------------------
   // bidirectional lines
   // ----------------------------------------------------------------
   assign host_in_v = {host_aux_line_b_in, host_aux_line_a_in, host_serial_in};
   assign card_in_v = {card_aux_line_b_in, card_aux_line_a_in, card_serial_line_in};

   generate
      for (genvar i = 0; i < NUM_LINES; i++)
      begin : g_line
         scd_line_buf u_line (
            .clk_sys(clk_sys),
            .rst(rst),
            .enable(line_en),
            .host_in(host_in_v[i]),
            .host_out(host_out_v[i]),
            .host_oe_n(host_oe_n_v[i]),
            .card_in(card_in_v[i]),
            .card_out(card_out_v[i]),
            .card_oe_n(card_oe_n_v[i])
         );
      end
   endgenerate

   assign host_serial_out = host_out_v[LN_SERIAL];
   assign host_serial_oe_n = host_oe_n_v[LN_SERIAL];
   assign host_aux_line_a_out = host_out_v[LN_AUX_A];
   assign host_aux_line_a_oe_n = host_oe_n_v[LN_AUX_A];
   assign host_aux_line_b_out = host_out_v[LN_AUX_B];
   assign host_aux_line_b_oe_n = host_oe_n_v[LN_AUX_B];
   assign card_serial_line_out = card_out_v[LN_SERIAL];
   assign card_serial_line_oe_n = card_oe_n_v[LN_SERIAL];
   assign card_aux_line_a_out = card_out_v[LN_AUX_A];
   assign card_aux_line_a_oe_n = card_oe_n_v[LN_AUX_A];
   assign card_aux_line_b_out = card_out_v[LN_AUX_B];
   assign card_aux_line_b_oe_n = card_oe_n_v[LN_AUX_B];

   // ----------------------------------------------------------------
   // activation and deactivation sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      cmd_prev_nxt = activate_cmd_n;
      cmd_fall = cmd_prev_r && !activate_cmd_n;
      deact = activate_cmd_n || !present || (|flt_now);
      step_done = (step_r == STEP_W'(STEP_CYC - 1));
      seq_nxt = seq_r;
      step_nxt = step_done ? '0 : step_r + STEP_W'(1);
      case (seq_r)
         SEQ_IDLE:
         begin
            step_nxt = '0;
            if (cmd_fall && present && !(|flt_now))
               seq_nxt = SEQ_VCC;
         end
         SEQ_VCC:
            if (deact)
               seq_nxt = SEQ_OFF_RST;
            else if (step_done)
               seq_nxt = SEQ_IO;
         SEQ_IO:
            if (deact)
               seq_nxt = SEQ_OFF_RST;
            else if (step_done)
               seq_nxt = SEQ_CLK;
         SEQ_CLK:
            if (deact)
               seq_nxt = SEQ_OFF_RST;
            else if (step_done)
               seq_nxt = SEQ_RUN;
         SEQ_RUN:
         begin
            step_nxt = '0;
            if (deact)
               seq_nxt = SEQ_OFF_RST;
         end
         SEQ_OFF_RST:
            if (step_done)
               seq_nxt = SEQ_OFF_CLK;
         SEQ_OFF_CLK:
            if (step_done)
               seq_nxt = SEQ_OFF_IO;
         SEQ_OFF_IO:
            if (step_done)
               seq_nxt = SEQ_IDLE;
         default:
            seq_nxt = SEQ_IDLE;
      endcase
      if (!host_supply_ok)
      begin
         seq_nxt = SEQ_IDLE;
         step_nxt = '0;
      end
      if (seq_nxt != seq_r)
         step_nxt = '0;
      sup_on_nxt = (seq_nxt != SEQ_IDLE);
      // supply level is frozen while the card is powered
      sup_5v_nxt = sup_on_r ? sup_5v_r : card_supply_sel;
      rst_out_nxt = (seq_nxt == SEQ_RUN) && host_reset_in;
   end

   // clock runs from its step through the reset-off step on the way down, stopping when SEQ_OFF_CLK begins
   assign clk_en = (seq_r == SEQ_CLK) || (seq_r == SEQ_RUN) || (seq_r == SEQ_OFF_RST);
   assign line_en = clk_en || (seq_r == SEQ_IO) || (seq_r == SEQ_OFF_CLK);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         seq_r <= SEQ_IDLE;
         step_r <= '0;
         cmd_prev_r <= 1'b1;
         sup_on_r <= 1'b0;
         sup_5v_r <= 1'b0;
         rst_out_r <= 1'b0;
      end
      else
      begin
         seq_r <= seq_nxt;
         step_r <= step_nxt;
         cmd_prev_r <= cmd_prev_nxt;
         sup_on_r <= sup_on_nxt;
         sup_5v_r <= sup_5v_nxt;
         rst_out_r <= rst_out_nxt;
      end
   end

   assign card_supply_out = sup_on_r;
   assign card_supply_5v = sup_5v_r;
   assign card_reset_out = rst_out_r;

   // ----------------------------------------------------------------
   // events, status, mask, interrupt and register port
   // ----------------------------------------------------------------
   always_comb
   begin
      flt_now[EV_OVLD] = fault_overload;
      flt_now[EV_HEAT] = fault_overheat;
      flt_now[EV_DROP] = (sup_on_r && !card_supply_ok) || !host_supply_ok;
      flt_prev_nxt = flt_now;
      pres_prev_nxt = present;
      ev[EV_PRES] = present != pres_prev_r;
      ev[NUM_EV-1:1] = flt_now & ~flt_prev_r;
      status_nxt = status_r;
      mask_nxt = mask_r;
      if (reg_wr && reg_addr == OFS_STATUS)
         status_nxt = status_r & ~reg_wdata[NUM_EV-1:0];
      if (reg_wr && reg_addr == OFS_MASK)
         mask_nxt = reg_wdata[NUM_EV-1:0];
      // a new event wins over a clear in the same cycle
      status_nxt = status_nxt | ev;
      irq_n_nxt = !(|(status_nxt & mask_nxt));
      rdata_nxt = '0;
      if (reg_rd)
      begin
         case (reg_addr)
            OFS_STATUS: rdata_nxt[NUM_EV-1:0] = status_r;
            OFS_MASK: rdata_nxt[NUM_EV-1:0] = mask_r;
            OFS_STATE:
            begin
               rdata_nxt[ST_BIT_PRES] = present;
               rdata_nxt[ST_BIT_SUP] = sup_on_r;
               rdata_nxt[ST_BIT_CLK] = clk_en;
               rdata_nxt[ST_BIT_LINE] = line_en;
               rdata_nxt[2:0] = seq_r;
            end
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         flt_prev_r <= '0;
         pres_prev_r <= 1'b0;
         status_r <= STATUS_RST;
         mask_r <= MASK_RST;
         irq_n_r <= 1'b1;
         rdata_r <= '0;
      end
      else
      begin
         flt_prev_r <= flt_prev_nxt;
         pres_prev_r <= pres_prev_nxt;
         status_r <= status_nxt;
         mask_r <= mask_nxt;
         irq_n_r <= irq_n_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign irq_n = irq_n_r;
   assign reg_rdata = rdata_r;

endmodule

// ----------------------------------------------------------------
// presence debounce: insertion waits the full count, removal is immediate
// ----------------------------------------------------------------
module scd_debounce
#(
   parameter int CNT_W = 19,
   parameter int CNT_MAX = 320000
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic raw_in,
   output logic present
);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic pres_r;
   logic pres_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      pres_nxt = pres_r;
      if (!raw_in)
      begin
         cnt_nxt = '0;
         pres_nxt = 1'b0;
      end
      else if (!pres_r)
      begin
         if (cnt_r == CNT_W'(CNT_MAX - 1))
            pres_nxt = 1'b1;
         else
            cnt_nxt = cnt_r + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cnt_r <= '0;
         pres_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         pres_r <= pres_nxt;
      end
   end

   assign present = pres_r;

endmodule

// ### hdl/scd_clk_div.sv
// card clock divider: divides the sampled external clock by 1, 2, 4 or 8
// assumes ext_clock_in is synchronous to clk_sys and at most half its rate
`timescale 1ns/100ps
module scd_clk_div
   import scd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic enable,
   input wire logic ext_clock_in,
   input wire logic [1:0] div_code,
   output logic clk_out
);

   logic ext_prev_r;
   logic ext_prev_nxt;
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;
   logic clk_out_r;
   logic clk_out_nxt;

   always_comb
   begin
      ext_prev_nxt = ext_clock_in;
      cnt_nxt = cnt_r;
      if (!enable)
         cnt_nxt = 3'h0;
      else if (ext_clock_in && !ext_prev_r)
         cnt_nxt = cnt_r + 3'h1;
      case (div_code)
         DIV_SEL_1: clk_out_nxt = ext_clock_in;
         DIV_SEL_2: clk_out_nxt = cnt_nxt[0];
         DIV_SEL_4: clk_out_nxt = cnt_nxt[1];
         DIV_SEL_8: clk_out_nxt = cnt_nxt[2];
         default: clk_out_nxt = 1'b0;
      endcase
      if (!enable)
         clk_out_nxt = 1'b0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ext_prev_r <= 1'b0;
         cnt_r <= 3'h0;
         clk_out_r <= 1'b0;
      end
      else
      begin
         ext_prev_r <= ext_prev_nxt;
         cnt_r <= cnt_nxt;
         clk_out_r <= clk_out_nxt;
      end
   end

   assign clk_out = clk_out_r;

endmodule

// ### hdl/scd_line_buf.sv
// open-drain bridge of one card line and its host-side mirror
// assumes both wires are pulled up outside and resolved by the surroundings
`timescale 1ns/100ps
module scd_line_buf
   import scd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic enable,
   input wire logic host_in,
   output logic host_out,
   output logic host_oe_n,
   input wire logic card_in,
   output logic card_out,
   output logic card_oe_n
);

   scd_own_t own_r;
   scd_own_t own_nxt;
   logic host_oe_n_r;
   logic host_oe_n_nxt;
   logic card_oe_n_r;
   logic card_oe_n_nxt;
   logic drive_lvl_r;

   always_comb
   begin
      own_nxt = own_r;
      case (own_r)
         OWN_IDLE:
            if (!host_in)
               own_nxt = OWN_HOST;
            else if (!card_in)
               own_nxt = OWN_CARD;
         OWN_HOST:
            if (host_in)
               own_nxt = OWN_SETTLE;
         OWN_CARD:
            if (card_in)
               own_nxt = OWN_SETTLE;
         OWN_SETTLE:
            own_nxt = OWN_IDLE;
         default:
            own_nxt = OWN_IDLE;
      endcase
      // a closed bridge waits in settle so its own held-low card contact is not seen as the card
      if (!enable)
         own_nxt = OWN_SETTLE;
      // released side rests high on its pull-up
      card_oe_n_nxt = !(own_nxt == OWN_HOST);
      host_oe_n_nxt = !(own_nxt == OWN_CARD);
      // a closed interface holds the card contact low
      if (!enable)
      begin
         card_oe_n_nxt = 1'b0;
         host_oe_n_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         own_r <= OWN_IDLE;
         host_oe_n_r <= 1'b1;
         card_oe_n_r <= 1'b0;
         drive_lvl_r <= 1'b0;
      end
      else
      begin
         own_r <= own_nxt;
         host_oe_n_r <= host_oe_n_nxt;
         card_oe_n_r <= card_oe_n_nxt;
         drive_lvl_r <= 1'b0;
      end
   end

   assign host_out = drive_lvl_r;
   assign host_oe_n = host_oe_n_r;
   assign card_out = drive_lvl_r;
   assign card_oe_n = card_oe_n_r;

endmodule

// ### hdl/scd_pkg.sv
// constants, register map and state types of the smart card interface control
// assumes a single 40 MHz system clock shared by every module
package scd_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int EXT_CLK_MAX_HZ = 20_000_000;
   localparam int DEBOUNCE_TIME_US = 8000;
   localparam int DEBOUNCE_CYC = DEBOUNCE_TIME_US * (CLK_HZ / 1_000_000);
   localparam int DEBOUNCE_W = 19;
   localparam int STEP_TIME_NS = 1000;
   localparam int STEP_CYC = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STEP_W = 8;

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_MASK = 4'h4;
   localparam logic [3:0] OFS_STATE = 4'h8;
   localparam int NUM_EV = 4;
   localparam int EV_PRES = 0;
   localparam int EV_OVLD = 1;
   localparam int EV_HEAT = 2;
   localparam int EV_DROP = 3;
   localparam logic [3:0] STATUS_RST = 4'h0;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam int ST_BIT_PRES = 7;
   localparam int ST_BIT_SUP = 6;
   localparam int ST_BIT_CLK = 5;
   localparam int ST_BIT_LINE = 4;

   // ----------------------------------------------------------------
   // divider select code {div_sel_b, div_sel_a}
   // ----------------------------------------------------------------
   localparam logic [1:0] DIV_SEL_1 = 2'h0;
   localparam logic [1:0] DIV_SEL_2 = 2'h1;
   localparam logic [1:0] DIV_SEL_4 = 2'h2;
   localparam logic [1:0] DIV_SEL_8 = 2'h3;

   // ----------------------------------------------------------------
   // line count and index
   // ----------------------------------------------------------------
   localparam int NUM_LINES = 3;
   localparam int LN_SERIAL = 0;
   localparam int LN_AUX_A = 1;
   localparam int LN_AUX_B = 2;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      SEQ_IDLE = 3'h0,
      SEQ_VCC = 3'h1,
      SEQ_IO = 3'h3,
      SEQ_CLK = 3'h2,
      SEQ_RUN = 3'h6,
      SEQ_OFF_RST = 3'h7,
      SEQ_OFF_CLK = 3'h5,
      SEQ_OFF_IO = 3'h4
   } scd_seq_t;

   typedef enum logic [1:0]
   {
      OWN_IDLE = 2'h0,
      OWN_HOST = 2'h1,
      OWN_CARD = 2'h3,
      OWN_SETTLE = 2'h2
   } scd_own_t;

endpackage

// ### sim/scd_card_if_bench.sv
// self-checking bench of the card interface top
// assumes scd_pkg, scd_card_if, scd_card_model and the bound checker
`timescale 1ns/100ps
module scd_card_if_bench import scd_pkg::*;;
   localparam int DEB = 16;
   logic clk_sys, rst, div_sel_a, div_sel_b, ext_clock_in, card_supply_sel;
   logic activate_cmd_n, host_reset_in, fault_overload, fault_overheat;
   logic card_supply_ok, host_supply_ok, inserted, use_low, card_detect_in, card_detect_in_n;
   logic card_supply_out, card_supply_5v, card_clock_out, card_reset_out, irq_n, reg_wr, reg_rd;
   logic [2:0] card_drv, host_drv, card_oe_n, host_oe_n, card_in, host_in, card_o, host_o;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   int failures, tests_run, rises;
   // ----------------------------------------------------------------
   // design, card and host wires
   // ----------------------------------------------------------------
   scd_card_if #(.DEBOUNCE_COUNT(DEB)) dut_u
   (
      .clk_sys, .rst, .div_sel_a, .div_sel_b, .ext_clock_in, .card_supply_sel,
      .card_detect_in_n, .card_detect_in, .activate_cmd_n, .host_reset_in,
      .fault_overload, .fault_overheat, .card_supply_ok, .host_supply_ok,
      .card_supply_out, .card_supply_5v, .card_clock_out, .card_reset_out,
      .host_serial_in(host_in[0]), .host_serial_out(host_o[0]), .host_serial_oe_n(host_oe_n[0]),
      .host_aux_line_a_in(host_in[1]), .host_aux_line_a_out(host_o[1]),
      .host_aux_line_a_oe_n(host_oe_n[1]), .host_aux_line_b_in(host_in[2]),
      .host_aux_line_b_out(host_o[2]), .host_aux_line_b_oe_n(host_oe_n[2]),
      .card_serial_line_in(card_in[0]), .card_serial_line_out(card_o[0]),
      .card_serial_line_oe_n(card_oe_n[0]), .card_aux_line_a_in(card_in[1]),
      .card_aux_line_a_out(card_o[1]), .card_aux_line_a_oe_n(card_oe_n[1]),
      .card_aux_line_b_in(card_in[2]), .card_aux_line_b_out(card_o[2]),
      .card_aux_line_b_oe_n(card_oe_n[2]),
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_n
   );
   scd_card_model card_u
   (
      .inserted, .use_low, .drive_low(card_drv), .line_oe_n(card_oe_n),
      .detect(card_detect_in), .detect_n(card_detect_in_n), .line_in(card_in)
   );
   assign host_in = ~(host_drv | ~host_oe_n);
   initial
   begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = !clk_sys;
   end
   always @(posedge clk_sys) ext_clock_in <= !ext_clock_in;
   always @(posedge card_clock_out) rises <= rises + 1;
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic activate(input logic [1:0] code);
      @(posedge clk_sys);
      {div_sel_b, div_sel_a} <= code;
      activate_cmd_n <= 1'h0;
      host_reset_in <= 1'h1;
      cyc(2);
      chk({card_oe_n, 4'h0, card_supply_out}, 8'h01);
      cyc(41);
      chk({card_oe_n, 4'h0, card_clock_out}, 8'hE0);
      cyc(81);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      #(25 * 30000);
      failures++;
      print_verdict;
   end
   initial
   begin
      {rst, div_sel_a, div_sel_b, ext_clock_in, card_supply_sel, host_reset_in} = 6'h20;
      {fault_overload, fault_overheat, inserted, use_low, reg_wr, reg_rd} = 6'h00;
      {activate_cmd_n, card_supply_ok, host_supply_ok} = 3'h7;
      {card_drv, host_drv, reg_addr, reg_wdata} = 18'h0;
      failures = 0;
      tests_run = 0;
      rises = 0;
      cyc(8);
      rst <= 1'h0;
      chk({host_oe_n, card_oe_n, 1'h0, irq_n}, 8'hE1);
      rdc(OFS_STATUS, 8'h00);
      rdc(OFS_MASK, 8'h00);
      wr(4'hC, 8'hFF);
      rdc(4'hC, 8'h00);
      $display("reset test done");
      inserted <= 1'h1;
      cyc(DEB / 2);
      rdc(OFS_STATE, 8'h00);
      cyc(DEB + 4);
      rdc(OFS_STATUS, 8'h01);
      wr(OFS_MASK, 8'h0F);
      cyc(1);
      chk(8'(irq_n), 8'h00);
      wr(OFS_STATUS, 8'h01);
      cyc(1);
      chk(8'(irq_n), 8'h01);
      rdc(OFS_STATE, 8'h80);
      $display("presence test done");
      for (int c = 0; c < 4; c++)
      begin
         card_supply_sel <= c[0];
         activate(c[1:0]);
         rdc(OFS_STATE, 8'hF6);
         chk({card_supply_5v, card_reset_out}, {c[0], 1'h1});
         rises <= 0;
         cyc(256);
         chk(8'(rises >= (128 >> c) - 1 && rises <= (128 >> c) + 1), 8'h01);
         if (c < 3)
         begin
            card_drv[c] <= 1'h1;
            cyc(3);
            chk(8'(host_oe_n), 8'(3'h7 & ~(3'h1 << c)));
            card_drv <= 3'h0;
            host_drv[c] <= 1'h1;
            cyc(4);
            chk(8'(card_oe_n), 8'(3'h7 & ~(3'h1 << c)));
            host_drv <= 3'h0;
            cyc(4);
            chk({card_in, host_in, 2'h0}, 8'hFC);
         end
         activate_cmd_n <= 1'h1;
         cyc(2);
         chk(8'(card_reset_out), 8'h00);
         cyc(50);
         chk({card_oe_n, card_clock_out, card_supply_out}, 8'h1D);
         cyc(40);
         chk({card_oe_n, card_supply_out}, 8'h01);
         cyc(40);
         chk(8'(card_supply_out), 8'h00);
      end
      $display("activation test done");
      for (int f = 0; f < 4; f++)
      begin
         activate(2'h0);
         {host_supply_ok, card_supply_ok, fault_overheat, fault_overload} <= 4'hC ^ (4'h1 << f);
         cyc(4);
         {host_supply_ok, card_supply_ok, fault_overheat, fault_overload} <= 4'hC;
         activate_cmd_n <= 1'h1;
         cyc(125);
         chk({card_supply_out, irq_n}, 8'h00);
         rdc(OFS_STATUS, (f < 2) ? (8'h02 << f) : 8'h08);
         wr(OFS_STATUS, 8'h0F);
      end
      $display("fault test done");
      wr(OFS_MASK, 8'h00);
      activate(2'h0);
      inserted <= 1'h0;
      cyc(125);
      chk({card_supply_out, irq_n}, 8'h01);
      rdc(OFS_STATUS, 8'h01);
      activate_cmd_n <= 1'h1;
      cyc(2);
      activate_cmd_n <= 1'h0;
      cyc(5);
      chk(8'(card_supply_out), 8'h00);
      use_low <= 1'h1;
      inserted <= 1'h1;
      cyc(DEB + 4);
      rdc(OFS_STATE, 8'h80);
      $display("removal test done");
      print_verdict;
   end
endmodule

// ### sim/scd_card_if_sva.sv
// checker of the card interface: sequencing, faults, lockout and line bridge
// assumes it is bound onto scd_card_if and sees only its ports
`timescale 1ns/100ps
module scd_card_if_sva
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic activate_cmd_n,
   input wire logic host_reset_in,
   input wire logic fault_overload,
   input wire logic fault_overheat,
   input wire logic host_supply_ok,
   input wire logic card_supply_out,
   input wire logic card_supply_5v,
   input wire logic card_clock_out,
   input wire logic card_reset_out,
   input wire logic host_serial_out,
   input wire logic host_serial_oe_n,
   input wire logic card_serial_line_in,
   input wire logic card_serial_line_out,
   input wire logic card_serial_line_oe_n
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_start_on_fall: assert property (
      $rose(card_supply_out) |-> !$past(activate_cmd_n) && $past(activate_cmd_n, 2))
      else $error("supply rose without a command fall");
   a_level_frozen: assert property (
      card_supply_out && $past(card_supply_out) |-> $stable(card_supply_5v))
      else $error("supply level changed while powered");
   a_clock_needs_sup: assert property (
      !card_supply_out && !$past(card_supply_out) |-> !card_clock_out)
      else $error("card clock runs without supply");
   a_reset_follows: assert property (
      card_reset_out |-> $past(host_reset_in))
      else $error("card reset high without host reset");
   a_fault_reset: assert property (
      fault_overload || fault_overheat |=> !card_reset_out)
      else $error("card reset kept during fault");
   a_fault_off: assert property (
      $rose(fault_overload) |-> ##[1:130] !card_supply_out)
      else $error("supply not removed after overload");
   a_lockout_off: assert property (
      !host_supply_ok [*4] |-> !card_supply_out && !card_clock_out && !card_reset_out)
      else $error("card contacts active under lockout");
   a_lines_low_on: assert property (
      $rose(card_supply_out) |-> !card_serial_line_oe_n)
      else $error("serial line released before supply");
   a_host_drv_cause: assert property (
      $fell(host_serial_oe_n) |-> !$past(card_serial_line_in) && $past(card_serial_line_oe_n))
      else $error("host line pulled low without card low");
   a_open_drain: assert property (
      !card_serial_line_out && !host_serial_out)
      else $error("line driven high");
   c_activation: cover property ($rose(card_supply_out));
   c_bridge: cover property ($fell(host_serial_oe_n));
   c_overload: cover property ($rose(fault_overload));
   c_lockout: cover property (!host_supply_ok [*4]);
endmodule

bind scd_card_if scd_card_if_sva sva_u (.*);

// ### sim/scd_card_model.sv
// card side: presence switch and open-drain card lines with pull-ups
// assumes the bench sets inserted, use_low and drive_low
`timescale 1ns/100ps
module scd_card_model
(
   input wire logic inserted,
   input wire logic use_low,
   input wire logic [2:0] drive_low,
   input wire logic [2:0] line_oe_n,
   output logic detect,
   output logic detect_n,
   output logic [2:0] line_in
);
   always_comb
   begin
      detect = inserted && !use_low;
      detect_n = !(inserted && use_low);
      line_in = ~(drive_low | ~line_oe_n);
   end
endmodule
